// *** hw/bist_link_if.sv ***
// Test access port link joining the scan controller and the self-test device.
`timescale 1ns/1ps
interface bist_link_if;
  logic tck;
  logic tms;
  logic tdi;
  logic tdo;

  // The controller makes the test clock and the mode and data bits.
  modport ctl (output tck, output tms, output tdi, input tdo);

  // The device only follows the link and answers on the data-out line.
  modport dev (input tck, input tms, input tdi, output tdo);
endinterface

// *** hw/bist_pkg.sv ***
// Shared constants and types for the boundary-scan memory self-test link.
package bist_pkg;

  // ---------------------------------------------------------------------------
  // Test access port states
  // ---------------------------------------------------------------------------
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR, TAP_PAUSE_DR, TAP_EXIT2_DR,
    TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } tap_state_t;

  // ---------------------------------------------------------------------------
  // Instructions (4-bit instruction register)
  // ---------------------------------------------------------------------------
  localparam int IR_W = 4;
  localparam logic [3:0] EXTEST_INSTR = 4'h0;
  localparam logic [3:0] FUNCTIONAL_BOUNDARY_ACCESS_INSTR = 4'h1;
  localparam logic [3:0] CONTROL_REGISTER_ACCESS_INSTR = 4'h2;
  localparam logic [3:0] BIST_RUN_INSTR = 4'h3;
  localparam logic [3:0] BYPASS_INSTR = 4'hf;
  localparam logic [3:0] IR_CAPTURE = 4'h1;

  // ---------------------------------------------------------------------------
  // Boundary register layout, shifted least significant bit first
  // ---------------------------------------------------------------------------
  localparam int BOUND_W = 34;
  localparam int BOUND_BLOCK_LSB = 0;
  localparam int BOUND_ADDR_LSB = 8;
  localparam int BOUND_DATA_LSB = 16;
  localparam int BOUND_MEMTEST_BIT = 32;
  localparam int BOUND_RW_BIT = 33;

  // ---------------------------------------------------------------------------
  // Boundary control register: [1:0] data code, [2] 16-bit generator, [3] address count-up
  // ---------------------------------------------------------------------------
  localparam int CREG_W = 4;
  localparam logic [1:0] CODE_GEN_AND_SIG = 2'h3;
  localparam logic [1:0] CODE_SIG_ONLY = 2'h2;
  localparam logic [1:0] CODE_COUNT_UP = 2'h1;
  localparam logic [1:0] CODE_TOGGLE = 2'h0;
  localparam int CREG_WIDE_BIT = 2;
  localparam int CREG_ADDR_COUNT_BIT = 3;
  localparam logic [3:0] CREG_RESET = 4'h3;
  localparam logic [7:0] LFSR8_TAPS = 8'hb8;
  localparam logic [15:0] LFSR16_TAPS = 16'hb400;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int TCK_PERIOD_NS = 80;
  localparam int TCK_HALF_CYCLES = TCK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam logic [15:0] RUN_TCKS_RESET = 16'h0100;
  localparam logic [15:0] RUN_TCKS_MIN = 16'h0003;

  // ---------------------------------------------------------------------------
  // Controller registers (APB byte offsets)
  // ---------------------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_BLOCK = 8'h04;
  localparam logic [7:0] REG_SEED = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_SIG = 8'h10;
  localparam logic [7:0] REG_RUNLEN = 8'h14;
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_RW_BIT = 1;
  localparam int CTRL_AUTO_BIT = 2;
  localparam int CTRL_CODE_LSB = 4;
  localparam int SEED_ADDR_LSB = 0;
  localparam int SEED_DATA_LSB = 16;

endpackage

// *** hw/bist_scan_controller.sv ***
// Scan controller that runs one memory-block self-test sequence over the test access port.
//
// The APB interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
// Operation
// - First instruction scan selects functional boundary access
// - Data scan loads block, seeds, memtest low, direction
// - Instruction scan selects control register access
// - Data scan loads mode code, device runs it
// - Run instruction; test values appear at Update-IR
// - Idle with run instruction starts generation, compression
// - Hold Run-Test/Idle exactly 256 test clocks; the code holds the REG_RUNLEN count, 256 after reset, at least 3
// - Functional instruction scan releases memtest high
// - Final data scan reads signature, loads next
// - Read data sampled on rising test clock
// - Addresses change after falling test clock
// - Increment block address before each further run
// - Random address never zero; seed kept nonzero
// - Address, data generator and compression modes
// - Toggle mode complement runs catch stuck bits
// - Count-up address mode visits every address
// - Tracker follows TAP on rising test clock
// - Active-low run indicator qualifies test select
module bist_scan_controller #(
  parameter int TCK_HALF = bist_pkg::TCK_HALF_CYCLES
) (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic [7:0] paddr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  bist_link_if.ctl link
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {SQ_IDLE, SQ_PRE, SQ_SHIFT, SQ_POST, SQ_STEP, SQ_RUN} seq_t;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
    logic shifting;
    logic [7:0] div;
    logic [1:0] tdo_s;
    seq_t seq;
    logic [2:0] step;
    logic [5:0] pre;
    logic [2:0] pre_n;
    logic [15:0] cnt;
    logic [33:0] tx;
    logic [33:0] rx;
    logic go;
    logic done;
    logic rw;
    logic auto_inc;
    logic [3:0] code;
    logic [7:0] block;
    logic [7:0] aseed;
    logic [15:0] dseed;
    logic [15:0] sig;
    logic [15:0] runlen;
    logic [31:0] prdata;
  } ctl_state_t;

  ctl_state_t r;
  ctl_state_t n;
  logic mapped;
  logic wr;
  logic rise;
  logic fall;
  logic busy;
  logic [7:0] seed_nz;
  logic [7:0] block_next;

  // ---------------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------------
  always_comb
  begin
    n = r;
    n.tdo_s = {r.tdo_s[0], link.tdo};
    busy = (r.seq != SQ_IDLE) || r.go;
    mapped = (paddr_in == bist_pkg::REG_CTRL) || (paddr_in == bist_pkg::REG_BLOCK) ||
             (paddr_in == bist_pkg::REG_SEED) || (paddr_in == bist_pkg::REG_STATUS) ||
             (paddr_in == bist_pkg::REG_SIG) || (paddr_in == bist_pkg::REG_RUNLEN);
    wr = psel_in && penable_in && pwrite_in && mapped;
    // A zero seed would lock the random address generator, so outside count-up mode it is stepped to one.
    seed_nz = (r.aseed == 8'h00 && !r.code[bist_pkg::CREG_ADDR_COUNT_BIT]) ? 8'h01 : r.aseed;
    block_next = r.auto_inc ? r.block + 8'h01 : r.block;

    // Read data are registered in the setup cycle so they stand for the whole access phase.
    if (psel_in && !penable_in)
    begin
      case (paddr_in)
        bist_pkg::REG_CTRL: n.prdata = {24'h0, r.code, 1'b0, r.auto_inc, r.rw, 1'b0};
        bist_pkg::REG_BLOCK: n.prdata = {24'h0, r.block};
        bist_pkg::REG_SEED: n.prdata = {r.dseed, 8'h00, r.aseed};
        bist_pkg::REG_STATUS: n.prdata = {24'h0, 1'b0, r.step, 2'h0, r.done, busy};
        bist_pkg::REG_SIG: n.prdata = {16'h0, r.sig};
        bist_pkg::REG_RUNLEN: n.prdata = {16'h0, r.runlen};
        default: n.prdata = 32'h0;
      endcase
    end

    // Configuration is frozen while a sequence runs; writes are honoured only when idle.
    if (wr && !busy)
    begin
      case (paddr_in)
        bist_pkg::REG_CTRL:
        begin
          n.go = pwdata_in[bist_pkg::CTRL_GO_BIT];
          n.done = r.done && !pwdata_in[bist_pkg::CTRL_GO_BIT];
          n.rw = pwdata_in[bist_pkg::CTRL_RW_BIT];
          n.auto_inc = pwdata_in[bist_pkg::CTRL_AUTO_BIT];
          n.code = pwdata_in[bist_pkg::CTRL_CODE_LSB +: 4];
        end
        bist_pkg::REG_BLOCK: n.block = pwdata_in[7:0];
        bist_pkg::REG_SEED:
        begin
          n.aseed = pwdata_in[bist_pkg::SEED_ADDR_LSB +: 8];
          n.dseed = pwdata_in[bist_pkg::SEED_DATA_LSB +: 16];
        end
        bist_pkg::REG_RUNLEN:
          n.runlen = (pwdata_in[15:0] < bist_pkg::RUN_TCKS_MIN) ? bist_pkg::RUN_TCKS_MIN : pwdata_in[15:0];
        default: ;
      endcase
    end

    // Test clock divider: the controller makes the link clock from its own clock.
    rise = 1'b0;
    fall = 1'b0;
    if (r.div == 8'(TCK_HALF - 1))
    begin
      n.div = 8'h00;
      n.tck = ~r.tck;
      rise = ~r.tck;
      fall = r.tck;
    end
    else
      n.div = r.div + 8'h01;

    // Data-out is sampled at the rising edge of each shift clock; after a 34-bit scan the first bit lands lowest.
    if (rise && r.shifting)
      n.rx = {r.tdo_s[1], r.rx[33:1]};

    // New TMS and TDI values are launched at the falling edge, half a period before use.
    if (fall)
    begin
      n.shifting = 1'b0;
      n.tms = 1'b0;
      case (r.seq)
        SQ_IDLE:
        begin
          if (r.go)
          begin
            n.go = 1'b0;
            n.step = 3'h0;
            n.pre = 6'h1f; // five ones reach Test-Logic-Reset, a zero lands in Idle
            n.pre_n = 3'h6;
            n.cnt = 16'h0000;
            n.seq = SQ_PRE;
          end
        end
        SQ_PRE:
        begin
          n.tms = r.pre[0];
          n.pre = {1'b0, r.pre[5:1]};
          n.pre_n = r.pre_n - 3'h1;
          if (r.pre_n == 3'h1)
            n.seq = (r.cnt == 16'h0000) ? SQ_STEP : SQ_SHIFT;
        end
        SQ_SHIFT:
        begin
          n.shifting = 1'b1;
          n.tms = (r.cnt == 16'h0001);
          n.tdi = r.tx[0];
          n.tx = {1'b0, r.tx[33:1]};
          n.cnt = r.cnt - 16'h0001;
          if (r.cnt == 16'h0001)
          begin
            n.pre_n = 3'h2;
            n.seq = SQ_POST;
          end
        end
        SQ_POST:
        begin
          // Exit1 to Update, then Update to Idle: every scan takes effect before the next.
          n.tms = (r.pre_n == 3'h2);
          n.pre_n = r.pre_n - 3'h1;
          if (r.pre_n == 3'h1)
            n.seq = SQ_STEP;
        end
        SQ_RUN:
        begin
          n.cnt = r.cnt - 16'h0001;
          if (r.cnt == 16'h0001)
          begin
            n.step = 3'h6;
            n.tx = {30'h0, bist_pkg::FUNCTIONAL_BOUNDARY_ACCESS_INSTR};
            n.cnt = 16'(bist_pkg::IR_W);
            n.pre = 6'h03;
            n.pre_n = 3'h4;
            n.seq = SQ_PRE;
          end
        end
        SQ_STEP:
        begin
          // One idle clock between steps; the run hold counts it as its first.
          n.seq = SQ_PRE;
          n.step = r.step + 3'h1;
          n.pre = 6'h03;
          n.pre_n = 3'h4;
          n.cnt = 16'(bist_pkg::IR_W);
          case (r.step)
            3'h0: n.tx = {30'h0, bist_pkg::FUNCTIONAL_BOUNDARY_ACCESS_INSTR};
            3'h1:
            begin
              n.tx = {r.rw, 1'b0, r.dseed, seed_nz, r.block};
              n.cnt = 16'(bist_pkg::BOUND_W);
              n.pre = 6'h01;
              n.pre_n = 3'h3;
            end
            3'h2: n.tx = {30'h0, bist_pkg::CONTROL_REGISTER_ACCESS_INSTR};
            3'h3:
            begin
              n.tx = {30'h0, r.code};
              n.cnt = 16'(bist_pkg::CREG_W);
              n.pre = 6'h01;
              n.pre_n = 3'h3;
            end
            3'h4: n.tx = {30'h0, bist_pkg::BIST_RUN_INSTR};
            3'h5:
            begin
              // Idle clocks: this one, the run count, and the first select clock of the next scan.
              n.step = r.step;
              n.cnt = r.runlen - 16'h0002;
              n.seq = SQ_RUN;
            end
            3'h6:
            begin
              n.tx = {r.rw, 1'b0, r.dseed, seed_nz, block_next};
              n.block = block_next;
              n.cnt = 16'(bist_pkg::BOUND_W);
              n.pre = 6'h01;
              n.pre_n = 3'h3;
            end
            default:
            begin
              n.sig = r.rx[bist_pkg::BOUND_DATA_LSB +: 16];
              n.done = 1'b1;
              n.step = 3'h0;
              n.seq = SQ_IDLE;
            end
          endcase
        end
        default: n.seq = SQ_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      r <= '0;
      r.code <= bist_pkg::CREG_RESET;
      r.runlen <= bist_pkg::RUN_TCKS_RESET;
    end
    else
      r <= n;
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign prdata_out = r.prdata;
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in && penable_in && !mapped;
  assign link.tck = r.tck;
  assign link.tms = r.tms;
  assign link.tdi = r.tdi;

endmodule

// *** hw/octal_bist_device.sv ***
// Self-test octal group with boundary register, pattern generators, signature and TAP tracker.
`timescale 1ns/1ps
module octal_bist_device (
  input wire logic clock_in,
  input wire logic resetn_in,
  bist_link_if.dev link,
  input wire logic [15:0] func_addr_in,
  input wire logic func_rw_in,
  input wire logic [15:0] func_wdata_in,
  input wire logic func_wdata_oe_in,
  input wire logic [15:0] mem_rdata_in,
  output logic [15:0] mem_addr_out,
  output logic buffered_read_write_out,
  output logic [15:0] buffered_data_bus_out,
  output logic buffered_data_bus_oe_out,
  output logic memtest_n_out,
  output logic test_cs_n_out,
  output logic run_n_out,
  output logic [3:0] tap_state_out
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] tck_s;
    logic [1:0] tms_s;
    logic [1:0] tdi_s;
    logic tck_d;
    bist_pkg::tap_state_t tap;
    logic [3:0] ir;
    logic [3:0] ir_sh;
    logic [33:0] dr_sh;
    logic [7:0] block;
    logic [7:0] addr;
    logic [15:0] data;
    logic memtest_n;
    logic rw;
    logic [3:0] boundary_control_register;
    logic [15:0] rdata_s0;
    logic [15:0] rdata_s1;
    logic tdo;
    logic test_cs_n;
    logic run_n;
  } dev_state_t;

  dev_state_t r;
  dev_state_t n;
  logic rise;
  logic fall;
  logic running;
  logic drive;
  logic bound_sel;
  logic ctl_sel;

  // Standard sixteen-state walk, advanced by TMS at each rising test clock.
  function automatic bist_pkg::tap_state_t tap_next(input bist_pkg::tap_state_t s, input logic tms);
    case (s)
      bist_pkg::TAP_RESET: tap_next = tms ? bist_pkg::TAP_RESET : bist_pkg::TAP_IDLE;
      bist_pkg::TAP_IDLE: tap_next = tms ? bist_pkg::TAP_SEL_DR : bist_pkg::TAP_IDLE;
      bist_pkg::TAP_SEL_DR: tap_next = tms ? bist_pkg::TAP_SEL_IR : bist_pkg::TAP_CAP_DR;
      bist_pkg::TAP_CAP_DR: tap_next = tms ? bist_pkg::TAP_EXIT1_DR : bist_pkg::TAP_SHIFT_DR;
      bist_pkg::TAP_SHIFT_DR: tap_next = tms ? bist_pkg::TAP_EXIT1_DR : bist_pkg::TAP_SHIFT_DR;
      bist_pkg::TAP_EXIT1_DR: tap_next = tms ? bist_pkg::TAP_UPD_DR : bist_pkg::TAP_PAUSE_DR;
      bist_pkg::TAP_PAUSE_DR: tap_next = tms ? bist_pkg::TAP_EXIT2_DR : bist_pkg::TAP_PAUSE_DR;
      bist_pkg::TAP_EXIT2_DR: tap_next = tms ? bist_pkg::TAP_UPD_DR : bist_pkg::TAP_SHIFT_DR;
      bist_pkg::TAP_UPD_DR: tap_next = tms ? bist_pkg::TAP_SEL_DR : bist_pkg::TAP_IDLE;
      bist_pkg::TAP_SEL_IR: tap_next = tms ? bist_pkg::TAP_RESET : bist_pkg::TAP_CAP_IR;
      bist_pkg::TAP_CAP_IR: tap_next = tms ? bist_pkg::TAP_EXIT1_IR : bist_pkg::TAP_SHIFT_IR;
      bist_pkg::TAP_SHIFT_IR: tap_next = tms ? bist_pkg::TAP_EXIT1_IR : bist_pkg::TAP_SHIFT_IR;
      bist_pkg::TAP_EXIT1_IR: tap_next = tms ? bist_pkg::TAP_UPD_IR : bist_pkg::TAP_PAUSE_IR;
      bist_pkg::TAP_PAUSE_IR: tap_next = tms ? bist_pkg::TAP_EXIT2_IR : bist_pkg::TAP_PAUSE_IR;
      bist_pkg::TAP_EXIT2_IR: tap_next = tms ? bist_pkg::TAP_UPD_IR : bist_pkg::TAP_SHIFT_IR;
      bist_pkg::TAP_UPD_IR: tap_next = tms ? bist_pkg::TAP_SEL_DR : bist_pkg::TAP_IDLE;
      default: tap_next = bist_pkg::TAP_RESET;
    endcase
  endfunction

  // ---------------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------------
  // Test clock edges are found on the synchronised copy, so the test clock must stay well below clock_in.
  always_comb
  begin
    n = r;
    n.tck_s = {r.tck_s[0], link.tck};
    n.tms_s = {r.tms_s[0], link.tms};
    n.tdi_s = {r.tdi_s[0], link.tdi};
    n.rdata_s0 = mem_rdata_in;
    n.rdata_s1 = r.rdata_s0;
    n.tck_d = r.tck_s[1];
    rise = r.tck_s[1] & ~r.tck_d;
    fall = ~r.tck_s[1] & r.tck_d;
    running = (r.tap == bist_pkg::TAP_IDLE) && (r.ir == bist_pkg::BIST_RUN_INSTR);
    bound_sel = (r.ir == bist_pkg::FUNCTIONAL_BOUNDARY_ACCESS_INSTR) || (r.ir == bist_pkg::EXTEST_INSTR);
    ctl_sel = (r.ir == bist_pkg::CONTROL_REGISTER_ACCESS_INSTR);
    if (rise)
    begin
      n.tap = tap_next(r.tap, r.tms_s[1]);
      case (r.tap)
        bist_pkg::TAP_CAP_IR: n.ir_sh = bist_pkg::IR_CAPTURE;
        bist_pkg::TAP_SHIFT_IR: n.ir_sh = {r.tdi_s[1], r.ir_sh[3:1]};
        bist_pkg::TAP_CAP_DR:
        begin
          // Capture hands the accumulated signature back in the data field.
          if (bound_sel)
            n.dr_sh = {r.rw, r.memtest_n, r.data, r.addr, r.block};
          else if (ctl_sel)
            n.dr_sh = {30'h0, r.boundary_control_register};
          else
            n.dr_sh = '0;
        end
        bist_pkg::TAP_SHIFT_DR:
        begin
          if (bound_sel)
            n.dr_sh = {r.tdi_s[1], r.dr_sh[33:1]};
          else if (ctl_sel)
            n.dr_sh = {30'h0, r.tdi_s[1], r.dr_sh[3:1]};
          else
            n.dr_sh = {33'h0, r.tdi_s[1]};
        end
        default: ;
      endcase
      // Read data are folded in on the rising edge, where the RAM select is released.
      if (running && r.rw && r.boundary_control_register[1])
        n.data = {r.data[14:0], ^(r.data & bist_pkg::LFSR16_TAPS)} ^ r.rdata_s1;
    end
    if (fall)
    begin
      n.tdo = (r.tap == bist_pkg::TAP_SHIFT_IR) ? r.ir_sh[0] : r.dr_sh[0];
      case (r.tap)
        bist_pkg::TAP_RESET: n.ir = bist_pkg::FUNCTIONAL_BOUNDARY_ACCESS_INSTR;
        bist_pkg::TAP_UPD_IR: n.ir = r.ir_sh;
        bist_pkg::TAP_UPD_DR:
        begin
          if (bound_sel)
          begin
            n.block = r.dr_sh[bist_pkg::BOUND_BLOCK_LSB +: 8];
            n.addr = r.dr_sh[bist_pkg::BOUND_ADDR_LSB +: 8];
            n.data = r.dr_sh[bist_pkg::BOUND_DATA_LSB +: 16];
            n.memtest_n = r.dr_sh[bist_pkg::BOUND_MEMTEST_BIT];
            n.rw = r.dr_sh[bist_pkg::BOUND_RW_BIT];
          end
          else if (ctl_sel)
            n.boundary_control_register = r.dr_sh[3:0];
        end
        default: ;
      endcase
      // Addresses move after the falling edge so they settle before the next rising-edge sample.
      if (running)
      begin
        if (r.boundary_control_register[bist_pkg::CREG_ADDR_COUNT_BIT])
          n.addr = r.addr + 8'h01;
        else if (r.addr == 8'h00)
          n.addr = 8'h01;
        else
          n.addr = {r.addr[6:0], ^(r.addr & bist_pkg::LFSR8_TAPS)};
        if (!r.rw)
        begin
          case (r.boundary_control_register[1:0])
            bist_pkg::CODE_GEN_AND_SIG:
            begin
              if (r.boundary_control_register[bist_pkg::CREG_WIDE_BIT])
                n.data = {r.data[14:0], ^(r.data & bist_pkg::LFSR16_TAPS)};
              else
                n.data = {r.data[14:8], ^(r.data[15:8] & bist_pkg::LFSR8_TAPS),
                          r.data[6:0], ^(r.data[7:0] & bist_pkg::LFSR8_TAPS)};
            end
            bist_pkg::CODE_TOGGLE: n.data = ~r.data;
            bist_pkg::CODE_COUNT_UP: n.data = r.data + 16'h0001;
            default: ;
          endcase
        end
      end
    end
    // Select only during the low half of the test clock, and never once memory-test is released.
    n.test_cs_n = ~(running && !r.memtest_n && !r.tck_s[1]);
    n.run_n = (r.tap != bist_pkg::TAP_IDLE);
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      r <= '0;
      r.ir <= bist_pkg::FUNCTIONAL_BOUNDARY_ACCESS_INSTR;
      r.memtest_n <= 1'b1;
      r.test_cs_n <= 1'b1;
      r.run_n <= 1'b1;
    end
    else
      r <= n;
  end

  // ---------------------------------------------------------------------------
  // Pins: test values drive the buses under Extest or the run instruction
  // ---------------------------------------------------------------------------
  assign drive = (r.ir == bist_pkg::EXTEST_INSTR) || (r.ir == bist_pkg::BIST_RUN_INSTR);
  assign mem_addr_out = drive ? {r.block, r.addr} : func_addr_in;
  assign buffered_read_write_out = drive ? r.rw : func_rw_in;
  assign buffered_data_bus_out = drive ? r.data : func_wdata_in;
  assign buffered_data_bus_oe_out = drive ? ~r.rw : func_wdata_oe_in;
  assign memtest_n_out = drive ? r.memtest_n : 1'b1;
  assign test_cs_n_out = r.test_cs_n;
  assign run_n_out = r.run_n;
  assign tap_state_out = r.tap;
  assign link.tdo = r.tdo;

endmodule

// *** test/bist_link_props.sv ***
// Link timing checks between scan controller and self-test device.
`timescale 1ns/1ps
module bist_link_props (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdo
);
  // The bench divider gives six clocks a phase, so a late move shows up before the fall.
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!resetn_in);
  a_tck_high: assert property ($rose(tck) |-> tck[*6] ##1 !tck) else $error("tck high");
  a_tck_low: assert property ($fell(tck) |-> !tck[*6]) else $error("tck low");
  a_tms_low: assert property ($changed(tms) |-> !tck) else $error("tms moved");
  a_tdi_low: assert property ($changed(tdi) |-> !tck) else $error("tdi moved");
  a_tdo_low: assert property ($changed(tdo) |-> !tck) else $error("tdo moved");
  a_scan_hold: assert property ($rose(tck) |-> ($stable(tms) && $stable(tdi))[*6]) else $error("scan hold");
  a_tdo_hold: assert property ($rose(tck) |-> $stable(tdo)[*7]) else $error("tdo hold");
  a_reset_quiet: assert property (disable iff (1'b0) !resetn_in |-> !tck && !tms && !tdi) else $error("reset");
  c_mode: cover property ($rose(tck) && tms);
  c_data: cover property ($rose(tck) && tdi);
  c_answer: cover property ($changed(tdo));
endmodule

// *** test/tb_boundary_scan_memory_bist.sv ***
// Bench joining the scan controller and the self-test device.
`timescale 1ns/1ps
module tb_boundary_scan_memory_bist;
  logic clock_in = 1'b0;
  logic resetn_in;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, rw, memtest_n, cs_n, tck_d, rwx;
  logic oe, run_n, tgl;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [15:0] mem_addr, sig, wdata;
  logic [15:0] rdata = 16'h5a3c;
  logic [15:0] fa = 16'h1234;
  logic [7:0] blk;
  logic [3:0] tap;
  int idle_cnt, zero_cnt, bad_cnt, compares, fail_count;
  bist_link_if link();
  always #2.5 clock_in = ~clock_in;
  bist_scan_controller #(.TCK_HALF(6)) u_bist_scan_controller (.clock_in(clock_in), .resetn_in(resetn_in),
    .paddr_in(paddr), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .link(link.ctl));
  octal_bist_device u_octal_bist_device (.clock_in(clock_in), .resetn_in(resetn_in), .link(link.dev),
    .func_addr_in(fa), .func_rw_in(1'b1), .func_wdata_in(16'h0), .func_wdata_oe_in(1'b0),
    .mem_rdata_in(rdata), .mem_addr_out(mem_addr), .buffered_read_write_out(rw),
    .buffered_data_bus_out(wdata), .buffered_data_bus_oe_out(oe), .memtest_n_out(memtest_n),
    .test_cs_n_out(cs_n), .run_n_out(run_n), .tap_state_out(tap));
  bist_link_props u_bist_link_props (.clock_in(clock_in), .resetn_in(resetn_in), .tck(link.tck),
    .tms(link.tms), .tdi(link.tdi), .tdo(link.tdo));
  // Count idle test clocks of a run and fold the constant read data as the device should.
  always @(posedge clock_in)
  begin
    tck_d <= link.tck;
    if (link.tck && !tck_d && tap === bist_pkg::TAP_IDLE && memtest_n === 1'b0)
    begin
      idle_cnt <= idle_cnt + 1;
      sig <= {sig[14:0], ^(sig & bist_pkg::LFSR16_TAPS)} ^ rdata;
    end
    if (cs_n === 1'b0 && mem_addr[7:0] === 8'h00)
      zero_cnt <= zero_cnt + 1;
    if (cs_n === 1'b0 && {mem_addr[15:8], rw, oe} !== {blk, rwx, ~rwx})
      bad_cnt <= bad_cnt + 1;
    // A toggle write may only ever show the seed or its complement on the data bus.
    if (cs_n === 1'b0 && tgl && wdata !== 16'hace1 && wdata !== 16'h531e)
      bad_cnt <= bad_cnt + 1;
  end
  task automatic close_out;
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer; the request holds until pready is seen high.
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q,
    output logic e);
    int n = 0;
    @(posedge clock_in);
    {paddr, pwrite, pwdata, psel} <= {a, w, d, 1'b1};
    @(posedge clock_in);
    penable <= 1'b1;
    do
    begin
      @(posedge clock_in);
      n++;
    end
    while (pready !== 1'b1 && n < 64);
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
    if (n == 64)
    begin
      fail_count++;
      close_out();
    end
  endtask
  // One block test, waited on through the done flag.
  task automatic run(input logic [7:0] b, input logic [31:0] seed, input logic [31:0] ctl);
    logic [31:0] q = 32'h0;
    logic e;
    int n = 0;
    {blk, rwx, sig, tgl} = {b, ctl[1], seed[31:16], ctl[7:1] == 7'h00};
    apb(bist_pkg::REG_BLOCK, 1'b1, {24'h0, b}, q, e);
    apb(bist_pkg::REG_SEED, 1'b1, seed, q, e);
    {idle_cnt, zero_cnt, bad_cnt} = '0;
    apb(bist_pkg::REG_CTRL, 1'b1, ctl, q, e);
    q = 32'h0;
    while (q[1] !== 1'b1 && n < 5000)
    begin
      apb(bist_pkg::REG_STATUS, 1'b0, 32'h0, q, e);
      n++;
    end
    chk(n < 5000, 1);
    if (n == 5000)
      close_out();
    chk(idle_cnt, 8);
    chk(bad_cnt, 0);
    chk(memtest_n, 1);
    chk(run_n, 0);
  endtask
  initial
  begin
    logic [31:0] q;
    logic e;
    logic [3:0] codes [4];
    codes = '{4'h0, 4'h1, 4'h7, 4'h3};
    resetn_in = 1'b0;
    repeat (20) @(posedge clock_in);
    resetn_in <= 1'b1;
    apb(bist_pkg::REG_RUNLEN, 1'b0, 32'h0, q, e);
    chk(q, 32'h100);
    chk(mem_addr, 16'h1234);
    apb(8'h20, 1'b0, 32'h0, q, e);
    chk({q[30:0], e}, 32'h1);
    apb(bist_pkg::REG_RUNLEN, 1'b1, 32'h8, q, e);
    for (int i = 0; i < 4; i++)
      run(8'h40 + i, 32'hace1005a, {24'h0, codes[i], 4'h1});
    chk(zero_cnt, 0);
    run(8'h44, 32'h000000fe, 32'hb1);
    chk(zero_cnt != 0, 1);
    run(8'h45, 32'hace1005a, 32'h27);
    apb(bist_pkg::REG_SIG, 1'b0, 32'h0, q, e);
    chk(q, {16'h0, sig});
    apb(bist_pkg::REG_BLOCK, 1'b0, 32'h0, q, e);
    chk(q, 32'h46);
    close_out();
  end
endmodule
